// File: safety_release_map.svh
// Bit positions, reset values and timing counts of the release logic
// Summary of operation
// RULE1: Request bit 6 acks discrepancy, bit 7 resets
// RULE2: Response bits 4..7: inputs, limit, warning, error
// RULE3: Warning bits: crosswire, temperature, internal, communication
// RULE4: Error bits: crosswire, temperature, actuator, internal, discrepancy
// RULE5: Power-up with feedback open: outputs off, 5 Hz
// RULE6: Auto variant enables outputs when feedback closes
// RULE7: Monitored variant enables on reset button release
// RULE8: Inputs off more than 500 ms apart trips
// RULE9: Discrepancy fault latched nonvolatile until acknowledged
// RULE10: Ack by button falling edge or serial command
// RULE11: Response bit 0 outputs on, bit 1 actuator
// RULE12: Error clears when cause gone and release
// RULE13: Warning lasting 30 minutes switches outputs off
// RULE14: Buttons synchronised and debounced before edge detection
// RULE15: Discrepancy counted on internal clock from first off
`ifndef SAFETY_RELEASE_MAP_SVH
`define SAFETY_RELEASE_MAP_SVH
`define REQ_ACK_DISC_BIT 6
`define REQ_ERR_RESET_BIT 7
`define RSP_OUT_ON_BIT 0
`define RSP_ACTUATOR_BIT 1
`define RSP_FEEDBACK_OPEN_BIT 3
`define RSP_INPUTS_BIT 4
`define RSP_LIMIT_BIT 5
`define RSP_WARNING_BIT 6
`define RSP_ERROR_BIT 7
`define DIAG_CROSSWIRE_BIT 2
`define DIAG_TEMP_BIT 3
`define DIAG_ACTUATOR_BIT 4
`define DIAG_INTERNAL_BIT 5
`define DIAG_COMM_BIT 6
`define DIAG_DISC_BIT 6
`define BYTE_RESET 8'h00
`define CLK_HZ 40000000
`define DISC_TIME_MS 500
`define DISC_CYCLES ((`CLK_HZ / 1000) * `DISC_TIME_MS)
`define WARN_TIME_MIN 30
`define WARN_CYCLES (64'd60 * `WARN_TIME_MIN * `CLK_HZ)
`define FLASH_HZ 5
`define FLASH_HALF_CYCLES (`CLK_HZ / (2 * `FLASH_HZ))
`define DEBOUNCE_TIME_MS 10
`define DEBOUNCE_CYCLES ((`CLK_HZ / 1000) * `DEBOUNCE_TIME_MS)
`endif

// File: safety_release_pkg.sv
// Types of the release logic
package safety_release_pkg;
  typedef enum logic [1:0] {st_blocked, st_wait_button, st_released}
    release_state_t;
endpackage : safety_release_pkg

// File: button_if.sv
// Debounced button level and release pulse
`timescale 1ns/1ps
interface button_if;
  logic level;
  logic fall;
  modport source (output level, output fall);
  modport sink (input level, input fall);
endinterface : button_if

// File: button_debounce.sv
// Synchroniser, debouncer and falling-edge detector for one button
`timescale 1ns/1ps
`include "safety_release_map.svh"
module button_debounce #(
  parameter int unsigned CYCLES = `DEBOUNCE_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic raw,
  button_if.source btn
);
  logic sync1, sync2, stable, fall;
  logic [31:0] cnt;
  logic next_stable, next_fall;
  logic [31:0] next_cnt;

  always_comb begin
    next_stable = stable;
    next_fall = 1'b0;
    next_cnt = 32'h0000_0000;
    if (sync2 != stable) begin
      if (cnt >= CYCLES - 1) begin
        next_stable = sync2;  // [RULE14]
        next_fall = stable & ~sync2;
      end else begin
        next_cnt = cnt + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      stable <= 1'b0;
      fall <= 1'b0;
      cnt <= 32'h0000_0000;
    end else begin
      sync1 <= raw;  // [RULE14]
      sync2 <= sync1;
      stable <= next_stable;
      fall <= next_fall;
      cnt <= next_cnt;
    end
  end

  assign btn.level = stable;
  assign btn.fall = fall;
endmodule : button_debounce

// File: safety_release.sv
// Output release, discrepancy monitor and diagnostic bytes
`timescale 1ns/1ps
`include "safety_release_map.svh"
module safety_release #(
  parameter longint unsigned WARN_CYCLES = `WARN_CYCLES,
  parameter int unsigned DISC_CYCLES = `DISC_CYCLES,
  parameter int unsigned DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic monitored_reset_variant,
  input wire logic disc_monitor_en,
  input wire logic safety_in_a,
  input wire logic safety_in_b,
  input wire logic feedback_closed,
  input wire logic reset_button,
  input wire logic ack_button,
  input wire logic actuator_detected,
  input wire logic actuator_in_limit,
  input wire logic actuator_wrong,
  input wire logic crosswire_fault,
  input wire logic over_temp,
  input wire logic internal_fault,
  input wire logic internal_warning,
  input wire logic comm_lost,
  input wire logic disc_fault_stored,
  input wire logic [7:0] request_byte,
  output logic [7:0] response_byte,
  output logic [7:0] warning_diag_byte,
  output logic [7:0] error_diag_byte,
  output logic safety_out_a,
  output logic safety_out_b,
  output logic yellow_led,
  output logic disc_fault_store
);
  // ****************************************************************
  // Button conditioning
  // ****************************************************************
  button_if rst_btn ();
  button_if ack_btn ();

  button_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_rst (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .raw(reset_button),
    .btn(rst_btn)
  );

  button_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_ack (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .raw(ack_button),
    .btn(ack_btn)
  );

  // ****************************************************************
  // State
  // ****************************************************************
  safety_release_pkg::release_state_t state, next_state;
  logic outs_on, next_outs_on;
  logic disc_latched, next_disc_latched;
  logic disc_loaded, next_disc_loaded;
  logic disc_run, next_disc_run;
  logic [31:0] disc_cnt, next_disc_cnt;
  logic [63:0] warn_cnt, next_warn_cnt;
  logic warn_trip, next_warn_trip;
  logic err_latched, next_err_latched;
  logic req7_q, next_req7_q;
  logic in_a_q, in_b_q;
  logic [31:0] flash_cnt, next_flash_cnt;
  logic flash, next_flash;
  logic led, next_led;
  logic [7:0] next_rsp, next_warn, next_err;

  logic warn_any, err_cause, err_release, ack_ev, fault_any;

  always_comb begin
    warn_any = crosswire_fault | over_temp | internal_warning | comm_lost;
    err_cause = internal_fault | actuator_wrong;
    // Release by request bit 7 falling or guard opening
    err_release = (req7_q & ~request_byte[`REQ_ERR_RESET_BIT]) |
                  ~actuator_detected;  // [RULE12]
    ack_ev = ack_btn.fall | request_byte[`REQ_ACK_DISC_BIT];  // [RULE1] [RULE10]
    fault_any = disc_latched | err_latched | warn_trip;
  end

  // ****************************************************************
  // Discrepancy, error and warning supervision
  // ****************************************************************
  always_comb begin
    next_disc_loaded = 1'b1;
    next_disc_latched = disc_latched;
    next_disc_run = disc_run;
    next_disc_cnt = disc_cnt;
    next_req7_q = request_byte[`REQ_ERR_RESET_BIT];
    next_err_latched = err_latched;
    next_warn_cnt = 64'h0;
    next_warn_trip = warn_trip;
    if (!disc_loaded) begin
      next_disc_latched = disc_fault_stored;  // [RULE9]
    end else begin
      if (disc_monitor_en && !disc_run && (in_a_q != in_b_q) &&
          ((in_a_q & ~safety_in_a) | (in_b_q & ~safety_in_b) |
           (safety_in_a != safety_in_b))) begin
        next_disc_run = 1'b1;  // [RULE15]
        next_disc_cnt = 32'h0;
      end
      if (disc_run) begin
        if (safety_in_a == safety_in_b) begin
          next_disc_run = 1'b0;
        end else if (disc_cnt >= DISC_CYCLES) begin
          next_disc_latched = 1'b1;  // [RULE8]
          next_disc_run = 1'b0;
        end else begin
          next_disc_cnt = disc_cnt + 32'h1;  // [RULE15]
        end
      end
      if (ack_ev && !next_disc_latched) begin
        next_disc_latched = 1'b0;
      end else if (ack_ev && disc_latched && !(disc_run &&
               disc_cnt >= DISC_CYCLES)) begin
        next_disc_latched = 1'b0;  // [RULE10]
      end
    end
    if (err_cause) begin
      next_err_latched = 1'b1;
    end else if (err_release) begin
      next_err_latched = 1'b0;  // [RULE12]
    end
    if (warn_any) begin
      if (warn_cnt >= WARN_CYCLES - 1) begin
        next_warn_trip = 1'b1;  // [RULE13]
        next_warn_cnt = warn_cnt;
      end else begin
        next_warn_cnt = warn_cnt + 64'h1;
      end
    end else begin
      next_warn_trip = 1'b0;
    end
  end

  // ****************************************************************
  // Release sequence
  // ****************************************************************
  always_comb begin
    next_state = state;
    next_outs_on = 1'b0;
    case (state)
      safety_release_pkg::st_blocked: begin
        if (!fault_any && disc_loaded && feedback_closed &&  // [RULE9]
            actuator_detected) begin
          if (monitored_reset_variant) begin
            next_state = safety_release_pkg::st_wait_button;  // [RULE7]
          end else begin
            next_state = safety_release_pkg::st_released;  // [RULE6]
          end
        end
      end
      safety_release_pkg::st_wait_button: begin
        if (fault_any || !actuator_detected) begin
          next_state = safety_release_pkg::st_blocked;
        end else if (rst_btn.fall) begin
          next_state = safety_release_pkg::st_released;  // [RULE7]
        end
      end
      safety_release_pkg::st_released: begin
        if (fault_any || !actuator_detected) begin
          next_state = safety_release_pkg::st_blocked;  // [RULE8] [RULE13]
        end
      end
      default: next_state = safety_release_pkg::st_blocked;
    endcase
    if (next_state == safety_release_pkg::st_released) begin
      next_outs_on = 1'b1;
    end
  end

  // ****************************************************************
  // Indicator and diagnostic bytes
  // ****************************************************************
  always_comb begin
    next_flash_cnt = flash_cnt + 32'h1;
    next_flash = flash;
    if (flash_cnt >= `FLASH_HALF_CYCLES - 1) begin
      next_flash_cnt = 32'h0;
      next_flash = ~flash;
    end
    next_led = next_outs_on | (~next_outs_on & flash);  // [RULE5] [RULE6]
    next_rsp = `BYTE_RESET;
    next_rsp[`RSP_OUT_ON_BIT] = next_outs_on;  // [RULE11]
    next_rsp[`RSP_ACTUATOR_BIT] = actuator_detected;  // [RULE11]
    next_rsp[`RSP_FEEDBACK_OPEN_BIT] = actuator_detected & ~next_outs_on;
    next_rsp[`RSP_INPUTS_BIT] = safety_in_a & safety_in_b;  // [RULE2]
    next_rsp[`RSP_LIMIT_BIT] = actuator_in_limit;  // [RULE2]
    next_rsp[`RSP_WARNING_BIT] = warn_any | fault_any;  // [RULE2]
    next_rsp[`RSP_ERROR_BIT] = fault_any;  // [RULE2]
    next_warn = `BYTE_RESET;
    next_warn[`DIAG_CROSSWIRE_BIT] = crosswire_fault;  // [RULE3]
    next_warn[`DIAG_TEMP_BIT] = over_temp;  // [RULE3]
    next_warn[`DIAG_INTERNAL_BIT] = internal_warning;  // [RULE3]
    next_warn[`DIAG_COMM_BIT] = comm_lost;  // [RULE3]
    next_err = `BYTE_RESET;
    next_err[`DIAG_CROSSWIRE_BIT] = warn_trip & crosswire_fault;  // [RULE4]
    next_err[`DIAG_TEMP_BIT] = warn_trip & over_temp;  // [RULE4]
    next_err[`DIAG_ACTUATOR_BIT] = actuator_wrong;  // [RULE4]
    next_err[`DIAG_INTERNAL_BIT] = err_latched;  // [RULE4]
    next_err[`DIAG_DISC_BIT] = disc_latched;  // [RULE4]
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state <= safety_release_pkg::st_blocked;  // [RULE5]
      outs_on <= 1'b0;
      disc_latched <= 1'b0;
      disc_loaded <= 1'b0;
      disc_run <= 1'b0;
      disc_cnt <= 32'h0;
      warn_cnt <= 64'h0;
      warn_trip <= 1'b0;
      err_latched <= 1'b0;
      req7_q <= 1'b0;
      in_a_q <= 1'b0;
      in_b_q <= 1'b0;
      flash_cnt <= 32'h0;
      flash <= 1'b0;
      led <= 1'b0;
      response_byte <= `BYTE_RESET;
      warning_diag_byte <= `BYTE_RESET;
      error_diag_byte <= `BYTE_RESET;
    end else begin
      state <= next_state;
      outs_on <= next_outs_on;
      disc_latched <= next_disc_latched;
      disc_loaded <= next_disc_loaded;
      disc_run <= next_disc_run;
      disc_cnt <= next_disc_cnt;
      warn_cnt <= next_warn_cnt;
      warn_trip <= next_warn_trip;
      err_latched <= next_err_latched;
      req7_q <= next_req7_q;
      in_a_q <= safety_in_a;
      in_b_q <= safety_in_b;
      flash_cnt <= next_flash_cnt;
      flash <= next_flash;
      led <= next_led;
      response_byte <= next_rsp;
      warning_diag_byte <= next_warn;
      error_diag_byte <= next_err;
    end
  end

  assign safety_out_a = outs_on;
  assign safety_out_b = outs_on;
  assign yellow_led = led;
  assign disc_fault_store = disc_latched;  // [RULE9]
endmodule : safety_release

// File: safety_release_checker.sv
// Port assertions of the release logic
`timescale 1ns/1ps
module safety_release_checker #(parameter int unsigned DISC_CYCLES = 20) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic monitored_reset_variant,
  input wire logic disc_monitor_en,
  input wire logic safety_in_a,
  input wire logic safety_in_b,
  input wire logic feedback_closed,
  input wire logic reset_button,
  input wire logic actuator_detected,
  input wire logic internal_fault,
  input wire logic actuator_wrong,
  input wire logic disc_fault_stored,
  input wire logic [7:0] request_byte,
  input wire logic [7:0] response_byte,
  input wire logic [7:0] error_diag_byte,
  input wire logic safety_out_a,
  input wire logic safety_out_b
);
  int unsigned cnt;
  int unsigned next_cnt;
  logic differ;
  assign differ = disc_monitor_en && safety_in_a != safety_in_b;
  always_comb next_cnt = !differ ? 0 : (cnt < 99) ? cnt + 1 : cnt;
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn) cnt <= 0;
    else cnt <= next_cnt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence ready_s;
    $past(rstn, 3) && !monitored_reset_variant && feedback_closed &&
    actuator_detected && !safety_out_a && error_diag_byte == 8'h00 &&
    !response_byte[7] && !response_byte[6] && !internal_fault &&
    !actuator_wrong && safety_in_a && safety_in_b &&
    $past(safety_in_a == safety_in_b) &&
    $past(!internal_fault && !actuator_wrong);
  endsequence
  sequence idle_s;
    (!reset_button && monitored_reset_variant) [*8] ##0 !safety_out_a;
  endsequence
  AST_OUT_PAIR: assert property (safety_out_a == safety_out_b)
    else $error("outputs differ");
  AST_RSP_IN: assert property ($past(rstn) |->
    response_byte[4] == $past(safety_in_a && safety_in_b))
    else $error("input bit wrong");
  AST_FAULT_OFF: assert property (response_byte[7] |-> !safety_out_a)
    else $error("fault with outputs on");
  AST_DISC_OFF: assert property (error_diag_byte[6] |-> !safety_out_a)
    else $error("latched fault with outputs on");
  AST_AUTO_REL: assert property (ready_s |=> safety_out_a)
    else $error("no auto release");
  AST_MON_WAIT: assert property (idle_s |=> !safety_out_a)
    else $error("release without button");
  AST_DISC_TRIP: assert property (cnt == DISC_CYCLES + 2 |->
    ##[0:3] error_diag_byte[6]) else $error("no discrepancy latch");
  AST_ACK: assert property (error_diag_byte[6] && request_byte[6] &&
    !differ |-> ##[1:3] !error_diag_byte[6]) else $error("ack ignored");
  AST_STORED_HOLD: assert property ($past(rstn) &&
    !$past(rstn, 2) && $past(disc_fault_stored) |->
    !safety_out_a ##1 !safety_out_a) else $error("stored fault released");
endmodule : safety_release_checker
bind safety_release safety_release_checker #(.DISC_CYCLES(DISC_CYCLES))
  chk_i (
  .clk_sys(clk_sys),
  .rstn(rstn),
  .monitored_reset_variant(monitored_reset_variant),
  .disc_monitor_en(disc_monitor_en),
  .safety_in_a(safety_in_a),
  .safety_in_b(safety_in_b),
  .feedback_closed(feedback_closed),
  .reset_button(reset_button),
  .actuator_detected(actuator_detected),
  .internal_fault(internal_fault),
  .actuator_wrong(actuator_wrong),
  .disc_fault_stored(disc_fault_stored),
  .request_byte(request_byte),
  .response_byte(response_byte),
  .error_diag_byte(error_diag_byte),
  .safety_out_a(safety_out_a),
  .safety_out_b(safety_out_b)
);

// File: gateway_model.sv
// Gateway model that sends the request byte
`timescale 1ns/1ps
module gateway_model (
  input wire logic clk_sys,
  input wire logic ack,
  input wire logic err_reset,
  output logic [7:0] request_byte
);
  always_ff @(posedge clk_sys)
    request_byte <= {err_reset, ack, 6'h00};
endmodule : gateway_model

// File: safety_release_tb.sv
// Self-checking bench of the release logic
`timescale 1ns/1ps
module safety_release_tb;
  logic clk_sys, rstn, monitored_reset_variant, disc_monitor_en;
  logic safety_in_a, safety_in_b, feedback_closed, reset_button;
  logic ack_button, actuator_detected, actuator_in_limit, actuator_wrong;
  logic crosswire_fault, over_temp, internal_fault, internal_warning;
  logic comm_lost, disc_fault_stored, ack, err_reset, yellow_led;
  logic safety_out_a, safety_out_b, disc_fault_store;
  logic [7:0] request_byte, response_byte, warning_diag_byte;
  logic [7:0] error_diag_byte;
  logic [17:0] in_v;
  logic [31:0] rs = 32'h6bf2;
  int err_total = 0;
  int num_checks = 0;
  localparam int DM = 16, IA = 15, IB = 14, FB = 13, RB = 12, AB = 11;
  localparam int AD = 10, AW = 8, OT = 6, IFT = 5, DS = 2, RQA = 1, RQE = 0;
  assign {monitored_reset_variant, disc_monitor_en, safety_in_a,
    safety_in_b, feedback_closed, reset_button, ack_button,
    actuator_detected, actuator_in_limit, actuator_wrong, crosswire_fault,
    over_temp, internal_fault, internal_warning, comm_lost,
    disc_fault_stored, ack, err_reset} = in_v;
  safety_release #(.WARN_CYCLES(50), .DISC_CYCLES(20),
    .DEBOUNCE_CYCLES(2)) uut (.clk_sys(clk_sys), .rstn(rstn),
    .monitored_reset_variant(monitored_reset_variant),
    .disc_monitor_en(disc_monitor_en), .safety_in_a(safety_in_a),
    .safety_in_b(safety_in_b), .feedback_closed(feedback_closed),
    .reset_button(reset_button), .ack_button(ack_button),
    .actuator_detected(actuator_detected),
    .actuator_in_limit(actuator_in_limit), .actuator_wrong(actuator_wrong),
    .crosswire_fault(crosswire_fault), .over_temp(over_temp),
    .internal_fault(internal_fault), .internal_warning(internal_warning),
    .comm_lost(comm_lost), .disc_fault_stored(disc_fault_stored),
    .request_byte(request_byte), .response_byte(response_byte),
    .warning_diag_byte(warning_diag_byte),
    .error_diag_byte(error_diag_byte), .safety_out_a(safety_out_a),
    .safety_out_b(safety_out_b), .yellow_led(yellow_led),
    .disc_fault_store(disc_fault_store));
  gateway_model gw (.clk_sys(clk_sys), .ack(ack), .err_reset(err_reset),
    .request_byte(request_byte));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  function automatic logic [7:0] rsp_exp(input logic o, l, w);
    return {1'b0, w, l, 1'b1, ~o, 2'h1, o};
  endfunction : rsp_exp
  task automatic stop_test;
    if (err_total == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : wt
  task automatic put(input int i, input logic v, input int n);
    @(posedge clk_sys);
    in_v[i] <= v;
    wt(n);
  endtask : put
  task automatic rst(input logic [17:0] v);
    if ($time > 0) @(posedge clk_sys);
    rstn <= 1'b0;
    in_v <= v;
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    wt(3);
  endtask : rst
  // ****************
  // Scenarios
  // ****************
  initial begin
    rst(18'h0c400);
    chk({yellow_led, response_byte},
      {1'b0, rsp_exp(1'b0, 1'b0, 1'b0)});
    put(FB, 1'b1, 2);
    chk({yellow_led, response_byte}, 9'h113);
    repeat (10) begin
      rs = xs(rs);
      @(posedge clk_sys);
      in_v[9:3] <= {rs[4], 1'b0, rs[0], rs[1], 1'b0, rs[2], rs[3]};
      wt(2);
      chk(warning_diag_byte, {1'b0, rs[3:2], 1'b0, rs[1:0], 2'h0});
      chk(response_byte, rsp_exp(1'b1, rs[4], |rs[3:0]));
    end
    rst(18'h0c400);
    put(FB, 1'b1, 3);
    put(IB, 1'b0, 30);
    chk({safety_out_a, error_diag_byte}, 9'h100);
    put(IB, 1'b1, 3);
    put(OT, 1'b1, 60);
    chk({response_byte[7:6], safety_out_a}, 3'h6);
    chk(error_diag_byte, 8'h08);
    rst(18'h0c400);
    put(FB, 1'b1, 3);
    put(IFT, 1'b1, 3);
    chk({response_byte[7], safety_out_a, error_diag_byte}, 10'h220);
    put(IFT, 1'b0, 3);
    chk(error_diag_byte, 8'h20);
    put(RQE, 1'b1, 3);
    put(RQE, 1'b0, 4);
    chk({safety_out_a, error_diag_byte}, 9'h100);
    put(DM, 1'b1, 1);
    put(IB, 1'b0, 12);
    put(IB, 1'b1, 3);
    chk(error_diag_byte, 8'h00);
    put(IB, 1'b0, 30);
    chk({disc_fault_store, safety_out_a, error_diag_byte}, 10'h240);
    put(IB, 1'b1, 10);
    chk(safety_out_a, 1'b0);
    put(AB, 1'b1, 6);
    put(AB, 1'b0, 12);
    chk({disc_fault_store, safety_out_a, error_diag_byte}, 10'h100);
    put(IA, 1'b0, 30);
    put(IA, 1'b1, 2);
    chk(error_diag_byte, 8'h40);
    put(RQA, 1'b1, 1);
    put(RQA, 1'b0, 4);
    chk(error_diag_byte, 8'h00);
    put(AW, 1'b1, 3);
    chk({safety_out_a, error_diag_byte}, 9'h030);
    put(AW, 1'b0, 3);
    chk(error_diag_byte, 8'h20);
    put(AD, 1'b0, 3);
    chk({safety_out_a, error_diag_byte}, 9'h000);
    put(AD, 1'b1, 3);
    chk(safety_out_a, 1'b1);
    rst(18'h2c400);
    put(FB, 1'b1, 10);
    chk(response_byte, rsp_exp(1'b0, 1'b0, 1'b0));
    put(RB, 1'b1, 6);
    chk(safety_out_a, 1'b0);
    put(RB, 1'b0, 10);
    chk({yellow_led, response_byte}, 9'h113);
    rst(18'h0e404);
    put(FB, 1'b1, 3);
    chk({safety_out_a, error_diag_byte}, 9'h040);
    put(DS, 1'b0, 1);
    put(RQA, 1'b1, 1);
    put(RQA, 1'b0, 4);
    chk(safety_out_a, 1'b1);
    stop_test;
  end
  initial begin
    #200000;
    err_total++;
    stop_test;
  end
endmodule : safety_release_tb
